// ===== verilog/serial_bus_master_end.sv
// bus master end: makes the link clock by division and runs single-byte transfers
`timescale 1ns/1ns
module serial_bus_master_end (
  // system
  input wire logic mclk,
  input wire logic reset,
  // link
  serial_link_if.ctrl link,
  // request
  input wire logic req,
  input wire logic req_read,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_sub,
  input wire logic [7:0] req_data,
  // answer
  output logic ready,
  output logic done,
  output logic nacked,
  output logic [7:0] rdata
);
  import link_pkg::*;

  ctrl_state_t state_reg, state_next;
  logic [CNT_W-1:0] qcnt_reg, qcnt_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bitn_reg, bitn_next;
  logic [1:0] byten_reg, byten_next;
  logic [7:0] tx_reg, tx_next, rx_reg, rx_next, sub_reg, sub_next, data_reg, data_next;
  logic read_reg, read_next, flush_reg, flush_next, nack_reg, nack_next;
  logic scl_low_reg, scl_low_next, sda_low_reg, sda_low_next;
  logic ready_reg, ready_next, done_reg, done_next;
  logic [7:0] rdata_reg, rdata_next;
  logic meta_reg, sync_reg;
  logic tick, receiving;
  logic [1:0] last_byte;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    qcnt_next = qcnt_reg + 1'h1;
    ph_next = ph_reg;
    bitn_next = bitn_reg;
    byten_next = byten_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    sub_next = sub_reg;
    data_next = data_reg;
    read_next = read_reg;
    flush_next = flush_reg;
    nack_next = nack_reg;
    scl_low_next = scl_low_reg;
    sda_low_next = sda_low_reg;
    ready_next = ready_reg;
    done_next = 1'h0;
    rdata_next = rdata_reg;
    tick = (state_reg == M_WAIT) ? (qcnt_reg == SETTLE_LAST) : (qcnt_reg == QTR_LAST);
    receiving = read_reg & (byten_reg == 2'h1);
    last_byte = flush_reg ? 2'h0 : (read_reg ? 2'h1 : 2'h2);
    if (tick) begin
      qcnt_next = '0;
    end
    case (state_reg)
      M_WAIT: begin
        // no clocks until the supply is up, then a zero byte flushes the port
        if (tick) begin
          state_next = M_START;
          flush_next = 1'h1;
          tx_next = FLUSH_BYTE;
          sda_low_next = 1'h1;
        end
      end
      M_IDLE: begin
        qcnt_next = '0;
        // ready only after the flush; the user then writes all three channels
        if (req) begin
          state_next = M_START;
          ready_next = 1'h0;
          read_next = req_read;
          flush_next = 1'h0;
          nack_next = 1'h0;
          tx_next = {req_addr, req_read ? RW_READ : RW_WRITE};
          sub_next = req_sub;
          data_next = req_data;
          sda_low_next = 1'h1;
        end
      end
      M_START: begin
        if (tick) begin
          state_next = M_BIT;
          scl_low_next = 1'h1;
          ph_next = 2'h0;
          bitn_next = 4'h0;
          byten_next = 2'h0;
        end
      end
      M_BIT: begin
        if (tick) begin
          ph_next = ph_reg + 2'h1;
          case (ph_reg)
            // data moves only with the clock low; slot and read byte are released
            2'h0: sda_low_next = (bitn_reg < ACK_SLOT) & ~receiving & ~tx_reg[7];
            2'h1: scl_low_next = 1'h0;
            2'h2: begin
              if (bitn_reg < ACK_SLOT) begin
                rx_next = {rx_reg[6:0], sync_reg};
                tx_next = {tx_reg[6:0], 1'h0};
              end else if (~receiving & ~flush_reg & sync_reg) begin
                nack_next = 1'h1;
              end
            end
            default: begin
              scl_low_next = 1'h1;
              if (bitn_reg < ACK_SLOT) begin
                bitn_next = bitn_reg + 4'h1;
              end else if ((byten_reg == last_byte) | nack_reg) begin
                state_next = M_STOP;
                bitn_next = 4'h0;
              end else begin
                bitn_next = 4'h0;
                byten_next = byten_reg + 2'h1;
                tx_next = (byten_reg == 2'h0) ? sub_reg : data_reg;
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          ph_next = ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_low_next = 1'h1;
            2'h1: scl_low_next = 1'h0;
            2'h2: sda_low_next = 1'h0;
            default: begin
              // one spare quarter keeps bus free time before any new start
              state_next = M_IDLE;
              ready_next = 1'h1;
              done_next = ~flush_reg;
              if (read_reg & ~nack_reg) begin
                rdata_next = rx_reg;
              end
            end
          endcase
        end
      end
      default: state_next = M_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= M_WAIT;
      qcnt_reg <= '0;
      ph_reg <= 2'h0;
      bitn_reg <= 4'h0;
      byten_reg <= 2'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      sub_reg <= 8'h00;
      data_reg <= 8'h00;
      read_reg <= 1'h0;
      flush_reg <= 1'h0;
      nack_reg <= 1'h0;
      scl_low_reg <= 1'h0;
      sda_low_reg <= 1'h0;
      ready_reg <= 1'h0;
      done_reg <= 1'h0;
      rdata_reg <= 8'h00;
      meta_reg <= 1'h1;
      sync_reg <= 1'h1;
    end else begin
      state_reg <= state_next;
      qcnt_reg <= qcnt_next;
      ph_reg <= ph_next;
      bitn_reg <= bitn_next;
      byten_reg <= byten_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      sub_reg <= sub_next;
      data_reg <= data_next;
      read_reg <= read_next;
      flush_reg <= flush_next;
      nack_reg <= nack_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      meta_reg <= link.sda;
      sync_reg <= meta_reg;
    end
  end

  assign link.m_scl_o = 1'h0;
  assign link.m_scl_oe = scl_low_reg;
  assign link.m_sda_o = 1'h0;
  assign link.m_sda_oe = sda_low_reg;
  assign ready = ready_reg;
  assign done = done_reg;
  assign nacked = nack_reg;
  assign rdata = rdata_reg;
endmodule

// ===== verilog/link_pkg.sv
// shared constants and types for the serial control link and its two ends
// Behaviour
// - start condition opens every transfer
// - master clocks address and direction bit
// - data changes only while clock low
// - acknowledge ninth clock only on match
// - eight data bits then one acknowledge
// - stop condition releases link, await start
// - transmitter releases data during acknowledge slot
// - one data byte per write
// - read byte ends with master not-acknowledge
// - one data byte per read
// - channel registers unpredictable until written
// - master configures all three channels first
// - one clock releases stuck acknowledge
// - eight clocks flush the receive buffer
// - wait for supply before first clocks
// - address is fixed bits plus select pins
// - select pins used live, never latched
// - direction zero writes, one reads
// - write sends sub-address then data byte
// - master runs standard or fast rate; the master end here runs standard rate (100 kbit/s) only
package link_pkg;
  localparam int NUM_CH = 3;
  localparam logic [4:0] ADDR_FIXED = 5'h0b;
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ = 1'h1;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_LAST = 8'h03;
  localparam logic [7:0] FLUSH_BYTE = 8'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] LINE_IDLE = 2'h3;
  localparam int MCLK_NS = 100;
  localparam int LINK_KBPS = 100;
  localparam int BIT_NS = 1000000 / LINK_KBPS;
  localparam int SETTLE_US = 10;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] QTR_LAST = CNT_W'(BIT_NS / (4 * MCLK_NS) - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'((SETTLE_US * 1000 + MCLK_NS - 1) / MCLK_NS - 1);
  typedef logic [7:0] cfg_byte_t;
  typedef cfg_byte_t [NUM_CH-1:0] cfg_bank_t;
  typedef enum logic [2:0] {ST_ADDR, ST_SUB, ST_DATA, ST_RDACK, ST_READ, ST_DONE} port_state_t;
  typedef enum logic [2:0] {M_WAIT, M_IDLE, M_START, M_BIT, M_STOP} ctrl_state_t;
endpackage

// ===== verilog/serial_link_if.sv
// open-drain two-wire link joining the bus master end and the slave port
`timescale 1ns/1ns
interface serial_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // pull-ups hold both lines high unless an enabled driver pulls low
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport ctrl (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
  modport port (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

// ===== verilog/serial_control_slave_port.sv
// slave port: link logic on the link clock, channel bank mirrored into mclk
`timescale 1ns/1ns
module serial_control_slave_port (
  // system
  input wire logic mclk,
  input wire logic reset,
  // address select pins
  input wire logic addr_select_high_pin,
  input wire logic addr_select_low_pin,
  // link
  serial_link_if.port link,
  // channel configuration
  output link_pkg::cfg_bank_t channel_cfg,
  output logic cfg_update
);
  import link_pkg::*;

  // ----------------------------------------
  // line filter and frame tracking (mclk)
  // ----------------------------------------
  logic [1:0] meta_reg, meta_next;
  logic [1:0] sync_reg, sync_next;
  logic [1:0] last_reg, last_next;
  logic [1:0] filt_reg, filt_next;
  logic hold_reg, hold_next;
  logic wr_meta_reg, wr_meta_next;
  logic wr_sync_reg, wr_sync_next;
  logic wr_seen_reg, wr_seen_next;
  logic update_reg, update_next;
  cfg_bank_t cfg_reg, cfg_next;
  logic start_seen, stop_seen;

  // ----------------------------------------
  // link side (scl)
  // ----------------------------------------
  port_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic ack_reg, ack_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] sub_reg, sub_next;
  cfg_bank_t store_reg, store_next;
  logic wr_tgl_reg, wr_tgl_next;
  logic [1:0] sel_meta_reg, sel_sync_reg;
  logic sda_low_reg, sda_low_next;
  logic link_rst;
  logic [7:0] byte_in;
  logic addr_hit;
  logic sub_ok;
  logic [1:0] sub_idx;

  // ----------------------------------------
  // mclk group
  // ----------------------------------------
  always_comb begin
    meta_next = {link.sda, link.scl};
    sync_next = meta_reg;
    last_next = sync_reg;
    // a level moves only after two equal samples, so one-sample spikes vanish
    filt_next = (sync_reg & ~(sync_reg ^ last_reg)) | (filt_reg & (sync_reg ^ last_reg));
    start_seen = filt_reg[1] & ~filt_next[1] & filt_reg[0] & filt_next[0];
    stop_seen = ~filt_reg[1] & filt_next[1] & filt_reg[0] & filt_next[0];
    hold_next = hold_reg;
    if (start_seen | stop_seen) begin
      hold_next = 1'h1;
    end else if (~filt_reg[0]) begin
      hold_next = 1'h0;
    end
    wr_meta_next = wr_tgl_reg;
    wr_sync_next = wr_meta_reg;
    wr_seen_next = wr_sync_reg;
    update_next = wr_sync_reg ^ wr_seen_reg;
    // the bank is quiet for many link clocks after a write, so a plain copy is safe
    cfg_next = update_next ? store_reg : cfg_reg;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_reg <= LINE_IDLE;
      sync_reg <= LINE_IDLE;
      last_reg <= LINE_IDLE;
      filt_reg <= LINE_IDLE;
      hold_reg <= 1'h1;
      wr_meta_reg <= 1'h0;
      wr_sync_reg <= 1'h0;
      wr_seen_reg <= 1'h0;
      update_reg <= 1'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
      filt_reg <= filt_next;
      hold_reg <= hold_next;
      wr_meta_reg <= wr_meta_next;
      wr_sync_reg <= wr_sync_next;
      wr_seen_reg <= wr_seen_next;
      update_reg <= update_next;
    end
  end

  // no reset: the mirror shows whatever the bank holds until written
  always_ff @(posedge mclk) begin
    cfg_reg <= cfg_next;
  end

  // ----------------------------------------
  // link clock, rising edge: sample and decode
  // ----------------------------------------
  // held in reset while the bus is idle, so a stop or a stray state lets go of sda
  assign link_rst = reset | hold_reg;

  always_comb begin
    byte_in = {shift_reg[6:0], link.sda};
    addr_hit = (byte_in[7:1] == {ADDR_FIXED, sel_sync_reg});
    sub_ok = (sub_reg >= SUB_FIRST) & (sub_reg <= SUB_LAST);
    sub_idx = sub_reg[1:0] - 2'h1;
    shift_next = byte_in;
    state_next = state_reg;
    ack_next = ack_reg;
    tx_next = tx_reg;
    sub_next = sub_reg;
    store_next = store_reg;
    wr_tgl_next = wr_tgl_reg;
    cnt_next = (cnt_reg == ACK_SLOT) ? 4'h0 : cnt_reg + 4'h1;
    if (state_reg == ST_READ) begin
      tx_next = {tx_reg[6:0], 1'h0};
    end
    if (cnt_reg == ACK_SLOT) begin
      ack_next = 1'h0;
      if (state_reg == ST_RDACK) begin
        state_next = ST_READ;
        tx_next = sub_ok ? store_reg[sub_idx] : 8'h00;
      end
    end else if (cnt_reg == 4'h7) begin
      case (state_reg)
        ST_ADDR: begin
          ack_next = addr_hit;
          if (!addr_hit) begin
            state_next = ST_DONE;
          end else if (byte_in[0] == RW_READ) begin
            state_next = ST_RDACK;
          end else begin
            state_next = ST_SUB;
          end
        end
        ST_SUB: begin
          ack_next = 1'h1;
          sub_next = byte_in;
          state_next = ST_DATA;
        end
        ST_DATA: begin
          ack_next = 1'h1;
          state_next = ST_DONE;
          if (sub_ok) begin
            store_next[sub_idx] = byte_in;
            wr_tgl_next = ~wr_tgl_reg;
          end
        end
        ST_READ: state_next = ST_DONE;
        ST_RDACK: state_next = ST_RDACK;
        ST_DONE: state_next = ST_DONE;
        default: state_next = ST_DONE;
      endcase
    end
  end

  always_ff @(posedge link.scl or posedge link_rst) begin
    if (link_rst) begin
      state_reg <= ST_ADDR;
      cnt_reg <= 4'h0;
      ack_reg <= 1'h0;
      tx_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ack_reg <= ack_next;
      tx_reg <= tx_next;
    end
  end

  // bank, pointer and shift buffer start undefined and only clocks change them
  always_ff @(posedge link.scl) begin
    shift_reg <= shift_next;
    sub_reg <= sub_next;
    store_reg <= store_next;
  end

  // toggle and select synchronisers must survive the idle hold
  always_ff @(posedge link.scl or posedge reset) begin
    if (reset) begin
      wr_tgl_reg <= 1'h0;
      sel_meta_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
    end else begin
      wr_tgl_reg <= wr_tgl_next;
      sel_meta_reg <= {addr_select_high_pin, addr_select_low_pin};
      sel_sync_reg <= sel_meta_reg;
    end
  end

  // ----------------------------------------
  // link clock, falling edge: drive sda
  // ----------------------------------------
  always_comb begin
    // drive only while the clock is low, hold through the high phase
    sda_low_next = ack_reg | ((state_reg == ST_READ) & ~tx_reg[7]);
  end

  always_ff @(negedge link.scl or posedge link_rst) begin
    if (link_rst) begin
      sda_low_reg <= 1'h0;
    end else begin
      sda_low_reg <= sda_low_next;
    end
  end

  assign link.d_sda_o = 1'h0;
  assign link.d_sda_oe = sda_low_reg;
  assign channel_cfg = cfg_reg;
  assign cfg_update = update_reg;
endmodule

// ===== verification/serial_link_props.sv
// assertions on the two-wire link between the master end and the slave port
`timescale 1ns/1ns
module serial_link_props (
  // system
  input wire logic mclk,
  input wire logic reset,
  // link
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import link_pkg::*;
  // ----------------------------------------
  // bit tracking, sampled on mclk
  // ----------------------------------------
  logic scl_reg, sda_reg, ack_reg, ack_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] byte_reg, byte_next;
  logic [7:0] sh_reg, sh_next;
  logic start, stop, rise, nine;
  assign start = scl & scl_reg & sda_reg & ~sda;
  assign stop = scl & scl_reg & ~sda_reg & sda;
  assign rise = scl & ~scl_reg;
  assign nine = rise & (cnt_reg == 4'h8);
  always_comb begin
    cnt_next = cnt_reg;
    byte_next = byte_reg;
    sh_next = sh_reg;
    ack_next = ack_reg;
    if (start) begin
      cnt_next = 4'h0;
      byte_next = 2'h0;
    end else if (rise) begin
      cnt_next = (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
      if (cnt_reg == 4'h9) begin
        byte_next = byte_reg + 2'h1;
      end
      if (byte_reg == 2'h0 && cnt_reg < 4'h8) begin
        sh_next = {sh_reg[6:0], sda};
      end
      if (nine && byte_reg == 2'h0) begin
        ack_next = d_sda_oe;
      end
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
      cnt_reg <= 4'h0;
      byte_reg <= 2'h0;
      sh_reg <= 8'h00;
      ack_reg <= 1'h0;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      cnt_reg <= cnt_next;
      byte_reg <= byte_next;
      sh_reg <= sh_next;
      ack_reg <= ack_next;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_ACK_ONLY_FIXED: assert property (nine && byte_reg == 2'h0 && sh_reg[7:3] != ADDR_FIXED |-> !d_sda_oe)
    else $error("address ack given to a foreign address");
  AST_ACK_HOLD: assert property (nine && d_sda_oe |-> d_sda_oe [*8])
    else $error("ack dropped during ninth clock high");
  AST_WRITE_ACK: assert property (nine && ack_reg && !sh_reg[0] && (byte_reg == 2'h1 || byte_reg == 2'h2) |-> d_sda_oe)
    else $error("write byte not acknowledged");
  AST_READ_RELEASE: assert property (nine && ack_reg && sh_reg[0] && byte_reg == 2'h1 |-> !d_sda_oe [*8])
    else $error("slave holds data line in read ack slot");
  AST_MASTER_ACK_SLOT: assert property (nine |-> !m_sda_oe [*8])
    else $error("master drives data line in ack slot");
  AST_DEV_CHANGE_LOW: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("slave changed data line while clock high");
  AST_START_CLOCK: assert property (start |-> scl [*4] ##[1:40] !scl)
    else $error("start not followed by clocking");
  AST_STOP_RELEASE: assert property (stop |-> (sda && scl) [*8])
    else $error("link not released after stop");
  AST_FLUSH: assert property ($fell(reset) |-> ##[90:140] m_sda_oe)
    else $error("no flush frame after reset");
  // a clock high phase shorter than fast rate allows would break real slaves on the bus
  AST_SCL_HIGH_MIN: assert property (rise |-> scl [*6])
    else $error("clock high phase too short for the link rate");
  AST_LOW_ONLY: assert property (!m_scl_o && !m_sda_o && !d_sda_o)
    else $error("open-drain driver drives a high level");
  CV_WRITE: cover property (nine && byte_reg == 2'h2 && d_sda_oe);
  CV_READ: cover property (nine && byte_reg == 2'h1 && sh_reg[0]);
  CV_NACK: cover property (nine && byte_reg == 2'h0 && !d_sda_oe);
endmodule

// ===== verification/serial_control_slave_port_tb.sv
// self-checking bench: master end and slave port joined over the link
`timescale 1ns/1ns
module serial_control_slave_port_tb;
  import link_pkg::*;
  logic mclk, reset, req, req_read, sel_hi, sel_lo, ready, done, nacked, cfg_update;
  logic [6:0] req_addr;
  logic [7:0] req_sub, req_data, rdata;
  cfg_bank_t channel_cfg;
  int fail_count, total_checks, upd_count, ptr;
  int model_cfg[3];
  int exp_q[$];
  serial_link_if link();
  serial_bus_master_end serial_bus_master_end_inst (.mclk(mclk), .reset(reset), .link(link), .req(req),
    .req_read(req_read), .req_addr(req_addr), .req_sub(req_sub), .req_data(req_data), .ready(ready),
    .done(done), .nacked(nacked), .rdata(rdata));
  serial_control_slave_port serial_control_slave_port_inst (.mclk(mclk), .reset(reset),
    .addr_select_high_pin(sel_hi), .addr_select_low_pin(sel_lo), .link(link), .channel_cfg(channel_cfg),
    .cfg_update(cfg_update));
  serial_link_props serial_link_props_inst (.mclk(mclk), .reset(reset), .m_scl_o(link.m_scl_o),
    .m_scl_oe(link.m_scl_oe), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe), .d_sda_o(link.d_sda_o),
    .d_sda_oe(link.d_sda_oe), .scl(link.scl), .sda(link.sda));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [6:0] own();
    return {ADDR_FIXED, sel_hi, sel_lo};
  endfunction
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] s, input logic [7:0] d);
    int n;
    int u;
    logic hit;
    logic ok;
    hit = (a === own());
    ok = (s >= SUB_FIRST && s <= SUB_LAST);
    u = upd_count;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check("ready", {7'h0, ready}, 8'h01);
    req = 1'b1;
    req_read = rd;
    req_addr = a;
    req_sub = s;
    req_data = d;
    @(negedge mclk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check("done", {7'h0, done}, 8'h01);
    check("nacked", {7'h0, nacked}, {7'h0, !hit});
    check("idle", {6'h0, link.scl, link.sda}, {6'h0, LINE_IDLE});
    if (!rd) begin
      if (hit) begin
        ptr = s;
        if (ok) begin
          model_cfg[s - 1] = d;
        end
      end
      check("updates", 8'(upd_count - u), {7'h0, hit && ok});
      for (int k = 0; k < NUM_CH; k++) begin
        if (model_cfg[k] >= 0) begin
          check("cfg", channel_cfg[k], 8'(model_cfg[k]));
        end
      end
    end else if (hit) begin
      exp_q.push_back((ptr >= 1 && ptr <= 3) ? model_cfg[ptr - 1] : 0);
      check("rdata", rdata, 8'(exp_q.pop_front()));
    end
  endtask
  // ----------------------------------------
  // clock, watchdog, stimulus
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (cfg_update === 1'b1) begin
      upd_count++;
    end
  end
  initial begin
    #(80000 * MCLK_NS);
    fail_count++;
    final_report();
  end
  initial begin
    int s;
    reset = 1'b1;
    {req, req_read, sel_hi, sel_lo} = 4'h0;
    {req_addr, req_sub, req_data} = 23'h0;
    {fail_count, total_checks, upd_count, ptr} = {32'h0, 32'h0, 32'h0, 32'h0};
    model_cfg = '{-1, -1, -1};
    void'($urandom(32'h21c8b84f));
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    // a channel_cfg entry is not compared until its channel has been written
    for (s = 1; s <= NUM_CH; s++) begin
      xfer(1'b0, own(), 8'(s), 8'($urandom));
    end
    check("flush", 8'(upd_count), 8'h03);
    repeat (4) begin
      s = $urandom_range(3, 1);
      xfer(1'b0, own(), 8'(s), 8'($urandom));
      xfer(1'b1, own(), 8'h00, 8'h00);
    end
    // select pins are live, so a new level moves the address two link clocks later
    for (s = 0; s < 4; s++) begin
      @(negedge mclk);
      {sel_hi, sel_lo} = 2'(s);
      xfer(1'b0, own() ^ ((s == 3) ? 7'h40 : 7'(s + 1)), 8'h01, 8'($urandom));
      xfer(1'b0, own(), 8'(s % 3 + 1), 8'($urandom));
    end
    xfer(1'b1, own() ^ 7'h01, 8'h00, 8'h00);
    xfer(1'b0, own(), 8'h00, 8'($urandom));
    xfer(1'b1, own(), 8'h00, 8'h00);
    xfer(1'b0, own(), 8'h04, 8'($urandom));
    xfer(1'b1, own(), 8'h00, 8'h00);
    final_report();
  end
endmodule
